/* hdl/pmi_cfg.svh */
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH
`define PMI_PTR_CONFIG 8'h00
`define PMI_PTR_SHUNT 8'h01
`define PMI_PTR_RAIL 8'h02
`define PMI_PTR_POWER 8'h03
`define PMI_PTR_CURRENT 8'h04
`define PMI_CONFIG_RESET 16'h4127
`define PMI_RESULT_RESET 16'h0000
`define PMI_ADDR_BASE 3'h4
`define PMI_ALERT_ADDR 7'h0C
`define PMI_HS_CODE_TOP 5'h01
`define PMI_CFG_RST_BIT 15
`define PMI_TIMEOUT_MS 28
`define PMI_CLK_MHZ 100
`endif

/* hdl/pmi_pkg.sv */
`default_nettype none
package pmi_pkg;
	typedef enum logic [5:0] {
		PMI_IDLE = 6'h01,
		PMI_ADDR = 6'h02,
		PMI_ACK = 6'h04,
		PMI_RECV = 6'h08,
		PMI_SEND = 6'h10,
		PMI_MACK = 6'h20
	} pmi_state_type;
	typedef struct packed {
		logic [7:0] data;
		logic [1:0] idx;
	} pmi_wr_type;
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] rail;
		logic [15:0] power;
		logic [15:0] current;
	} pmi_meas_type;
endpackage
`default_nettype wire

/* hdl/pmi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pmi_sync
	import pmi_pkg::*;
#(
	parameter int WIDTH = 1
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_r <= '1;
			o_q <= '1;
		end
		else
		begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule // pmi_sync
`default_nettype wire

/* hdl/pmi_toggle.sv */
`timescale 1ns/1ps
`default_nettype none
module pmi_toggle
	import pmi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_tog,
	output logic o_pulse
);
	logic [2:0] s_r;
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			s_r <= 3'h0;
		else
			s_r <= {s_r[1:0], i_tog};
	end
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_pulse <= 1'b0;
		else
			o_pulse <= s_r[2] ^ s_r[1];
	end
endmodule // pmi_toggle
`default_nettype wire

/* hdl/pmi_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmi_cfg.svh"
module pmi_port
	import pmi_pkg::*;
#(
	parameter int TIMEOUT_CYC = `PMI_TIMEOUT_MS * 1000 * `PMI_CLK_MHZ
)(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic [1:0] i_addr_strap_low,
	input wire logic [1:0] i_addr_strap_high,
	input wire logic i_alert_pending,
	input wire logic i_cal_nonzero,
	input wire pmi_meas_type i_meas,
	input wire logic i_meas_clk,
	input wire logic i_meas_valid,
	output logic [15:0] o_config,
	output logic o_fast_plus_speed,
	output logic o_alert_n
);
	logic [1:0] bus_s;
	logic [3:0] strap_s;
	logic scl_d_r;
	logic sda_d_r;
	pmi_state_type st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] ptr_r;
	logic [1:0] wcnt_r;
	logic rd_r;
	logic alert_r;
	logic lost_r;
	logic [6:0] own_addr;
	logic [15:0] rd_word;
	logic [7:0] hi_r;
	logic byte_hi_r;
	logic [31:0] to_r;
	logic meas_tog_r;
	logic meas_pulse;
	pmi_meas_type meas_cap_r;
	pmi_meas_type meas_r;
	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	logic timeout;
	pmi_sync #(.WIDTH(2)) u_bus_sync (.i_clk(i_mclk), .i_rstn(i_rstn),
		.i_d({i_scl, i_sda}), .o_q(bus_s));
	pmi_sync #(.WIDTH(4)) u_strap_sync (.i_clk(i_mclk), .i_rstn(i_rstn),
		.i_d({i_addr_strap_high, i_addr_strap_low}), .o_q(strap_s));
	always_ff @(posedge i_meas_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meas_tog_r <= 1'b0;
			meas_cap_r <= '0;
		end
		else if (i_meas_valid)
		begin
			meas_tog_r <= ~meas_tog_r;
			meas_cap_r <= i_meas;
		end
	end
	pmi_toggle u_meas_xing (.i_clk(i_mclk), .i_rstn(i_rstn), .i_tog(meas_tog_r),
		.o_pulse(meas_pulse));
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			meas_r <= '0;
		else if (o_config[`PMI_CFG_RST_BIT])
			meas_r <= '0;
		else if (meas_pulse)
		begin
			meas_r.shunt <= meas_cap_r.shunt;
			meas_r.rail <= meas_cap_r.rail;
			meas_r.power <= i_cal_nonzero ? meas_cap_r.power : `PMI_RESULT_RESET;
			meas_r.current <= i_cal_nonzero ? meas_cap_r.current : `PMI_RESULT_RESET;
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= bus_s[1];
			sda_d_r <= bus_s[0];
		end
	end
	assign start_ev = bus_s[1] && scl_d_r && sda_d_r && !bus_s[0];
	assign stop_ev = bus_s[1] && scl_d_r && !sda_d_r && bus_s[0];
	assign scl_rise = bus_s[1] && !scl_d_r;
	assign scl_fall = !bus_s[1] && scl_d_r;
	assign timeout = (to_r == 32'(TIMEOUT_CYC));
	assign own_addr = {`PMI_ADDR_BASE, strap_s};
	always_comb
	begin
		unique case (ptr_r)
			`PMI_PTR_CONFIG: rd_word = o_config;
			`PMI_PTR_SHUNT: rd_word = meas_r.shunt;
			`PMI_PTR_RAIL: rd_word = meas_r.rail;
			`PMI_PTR_POWER: rd_word = meas_r.power;
			`PMI_PTR_CURRENT: rd_word = meas_r.current;
			default: rd_word = 16'h0000;
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			to_r <= 32'h0;
		else if (st_r == PMI_IDLE || scl_rise || scl_fall)
			to_r <= 32'h0;
		else if (!timeout)
			to_r <= to_r + 32'h1;
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_r <= PMI_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			ptr_r <= `PMI_PTR_CONFIG;
			wcnt_r <= 2'h0;
			rd_r <= 1'b0;
			alert_r <= 1'b0;
			lost_r <= 1'b0;
			hi_r <= 8'h00;
			byte_hi_r <= 1'b1;
			o_sda <= 1'b0;
			o_sda_oe <= 1'b0;
			o_config <= `PMI_CONFIG_RESET;
			o_fast_plus_speed <= 1'b0;
		end
		else if (timeout)
		begin
			st_r <= PMI_IDLE;
			o_sda_oe <= 1'b0;
		end
		else if (start_ev)
		begin
			st_r <= PMI_ADDR;
			bit_r <= 4'h0;
			wcnt_r <= 2'h0;
			o_sda_oe <= 1'b0;
		end
		else if (stop_ev)
		begin
			st_r <= PMI_IDLE;
			o_sda_oe <= 1'b0;
			o_fast_plus_speed <= 1'b0;
		end
		else
		begin
			if (o_config[`PMI_CFG_RST_BIT])
				o_config <= `PMI_CONFIG_RESET;
			unique case (st_r)
				PMI_IDLE:
				begin
					o_sda_oe <= 1'b0;
				end
				PMI_ADDR, PMI_RECV:
				begin
					if (scl_rise)
					begin
						sh_r <= {sh_r[6:0], bus_s[0]};
						bit_r <= bit_r + 4'h1;
					end
					else if (scl_fall && bit_r == 4'h8)
					begin
						bit_r <= 4'h0;
						st_r <= PMI_ACK;
						o_sda <= 1'b0;
						o_sda_oe <= 1'b1;
						if (st_r == PMI_ADDR)
						begin
							rd_r <= sh_r[0];
							alert_r <= 1'b0;
							lost_r <= 1'b0;
							if (sh_r[7:1] == own_addr)
								byte_hi_r <= 1'b1;
							else if (sh_r[7:1] == `PMI_ALERT_ADDR && sh_r[0] && i_alert_pending)
								alert_r <= 1'b1;
							else
							begin
								o_sda_oe <= 1'b0;
								st_r <= PMI_IDLE;
								if (sh_r[7:3] == `PMI_HS_CODE_TOP)
									o_fast_plus_speed <= 1'b1;
							end
						end
						else
						begin
							if (wcnt_r == 2'h0)
								ptr_r <= sh_r;
							else if (wcnt_r == 2'h1)
								hi_r <= sh_r;
							else if (wcnt_r == 2'h2 && ptr_r == `PMI_PTR_CONFIG)
								o_config <= {hi_r, sh_r};
							if (wcnt_r != 2'h3)
								wcnt_r <= wcnt_r + 2'h1;
						end
					end
				end
				PMI_ACK:
				begin
					if (scl_fall)
					begin
						o_sda_oe <= 1'b0;
						if (rd_r)
						begin
							st_r <= PMI_SEND;
							sh_r <= alert_r ? {own_addr, 1'b0}
								: (byte_hi_r ? rd_word[15:8] : rd_word[7:0]);
							o_sda_oe <= alert_r ? ~own_addr[6] : ~rd_word[15];
							if (!alert_r && !byte_hi_r)
								o_sda_oe <= ~rd_word[7];
						end
						else
							st_r <= PMI_RECV;
					end
				end
				PMI_SEND:
				begin
					if (scl_rise)
					begin
						if (alert_r && !o_sda_oe && !bus_s[0])
							lost_r <= 1'b1;
						bit_r <= bit_r + 4'h1;
					end
					else if (scl_fall)
					begin
						if (lost_r)
						begin
							st_r <= PMI_IDLE;
							o_sda_oe <= 1'b0;
						end
						else if (bit_r == 4'h8)
						begin
							bit_r <= 4'h0;
							o_sda_oe <= 1'b0;
							st_r <= PMI_MACK;
							byte_hi_r <= ~byte_hi_r;
						end
						else
						begin
							sh_r <= {sh_r[6:0], 1'b0};
							o_sda_oe <= ~sh_r[6];
						end
					end
				end
				PMI_MACK:
				begin
					if (scl_rise)
						st_r <= bus_s[0] ? PMI_IDLE : PMI_ACK;
				end
				default: st_r <= PMI_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_alert_n <= 1'b1;
		else
			o_alert_n <= ~i_alert_pending;
	end
	chk_nack_foreign: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == PMI_ADDR && scl_fall && bit_r == 4'h8 && sh_r[7:1] != own_addr
		&& sh_r[7:1] != `PMI_ALERT_ADDR) |=> !o_sda_oe)
		else $error("Foreign address acknowledged.");
	chk_hs_enter: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == PMI_ADDR && scl_fall && bit_r == 4'h8 && sh_r[7:3] == `PMI_HS_CODE_TOP
		&& !start_ev && !stop_ev && !timeout) |=> o_fast_plus_speed && !o_sda_oe)
		else $error("Master code mishandled.");
	chk_hs_exit: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		stop_ev && !timeout |=> !o_fast_plus_speed)
		else $error("Stop did not leave fast mode.");
	chk_ptr_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		rd_r && st_r != PMI_ADDR |=> $stable(ptr_r))
		else $error("Pointer changed during read.");
	chk_zero_cal: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!i_cal_nonzero && meas_pulse |=> meas_r.power == 16'h0000 && meas_r.current == 16'h0000)
		else $error("Result nonzero without calibration.");
	chk_timeout_idle: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		timeout |=> st_r == PMI_IDLE && !o_sda_oe)
		else $error("Timeout did not release bus.");
	chk_stop_release: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		stop_ev |=> st_r == PMI_IDLE ##1 !o_sda_oe)
		else $error("Stop did not release bus.");
	chk_ro_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		ptr_r != `PMI_PTR_CONFIG && !o_config[`PMI_CFG_RST_BIT] |=> $stable(o_config))
		else $error("Config changed by read-only write.");
	sequence data_byte_end;
		st_r == PMI_RECV && scl_fall && bit_r == 4'h8 && !start_ev && !stop_ev && !timeout;
	endsequence
	sequence ack_held;
		o_sda_oe ##1 o_sda_oe;
	endsequence
	chk_data_ack: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		data_byte_end |=> ack_held)
		else $error("Data byte not acknowledged.");
endmodule // pmi_port
`default_nettype wire

/* verif/pmi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module pmi_master
(
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	int half = 10;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic set(input logic c, input logic d);
		@(posedge i_mclk);
		o_scl <= c;
		o_sda <= d;
		hold(half);
	endtask
	task automatic bitx(input logic b, output logic r);
		set(1'b0, b);
		set(1'b1, b);
		r = i_sda;
	endtask
	task automatic start();
		set(o_scl, 1'b1);
		set(1'b1, 1'b1);
		set(1'b1, 1'b0);
	endtask
	task automatic stop();
		set(1'b0, 1'b0);
		set(1'b1, 1'b0);
		set(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, v[i]);
		bitx(~mack, r);
	endtask
endmodule // pmi_master
`default_nettype wire

/* verif/pmi_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmi_port_tb
	import pmi_pkg::*;
;
	localparam int TO = 2000;
	logic mclk = 1'b0, mck = 1'b0, rstn = 1'b0, alert = 1'b0, cal = 1'b0, mval = 1'b0;
	logic [1:0] sl = 2'h0, sh = 2'h0;
	pmi_meas_type meas = '0;
	logic sda_oe, sda_o, fast, alert_n, a;
	logic [15:0] cfg, v, d;
	logic [7:0] b;
	logic [6:0] ad;
	wire logic scl, msda;
	wire logic sda = msda & ~(sda_oe & ~sda_o);
	int mismatches = 0, cmp_count = 0;
	always #5 mclk = ~mclk;
	always #3 mck = ~mck;
	pmi_port #(.TIMEOUT_CYC(TO)) uut (.i_mclk(mclk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
		.o_sda(sda_o), .o_sda_oe(sda_oe), .i_addr_strap_low(sl), .i_addr_strap_high(sh),
		.i_alert_pending(alert), .i_cal_nonzero(cal), .i_meas(meas), .i_meas_clk(mck),
		.i_meas_valid(mval), .o_config(cfg), .o_fast_plus_speed(fast), .o_alert_n(alert_n));
	pmi_master m (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [15:0] exp_res(input logic c, input logic [15:0] w);
		return c ? w : 16'h0000;
	endfunction
	task automatic wr(input logic [7:0] p, input logic [15:0] w, input bit two);
		m.start();
		m.wbyte({ad, 1'b0}, a);
		chk("addr ack", 16'h1, 16'(a));
		m.wbyte(p, a);
		chk("ptr ack", 16'h1, 16'(a));
		if (two)
		begin
			m.wbyte(w[15:8], a);
			chk("hi ack", 16'h1, 16'(a));
			m.wbyte(w[7:0], a);
			chk("lo ack", 16'h1, 16'(a));
		end
		m.stop();
	endtask
	task automatic rd(output logic [15:0] r);
		m.start();
		m.wbyte({ad, 1'b1}, a);
		chk("rd ack", 16'h1, 16'(a));
		m.rbyte(1'b1, r[15:8]);
		m.rbyte(1'b0, r[7:0]);
		m.stop();
	endtask
	task automatic send_meas();
		@(posedge mck);
		meas <= {$urandom, $urandom};
		mval <= 1'b1;
		@(posedge mck);
		mval <= 1'b0;
		repeat (20) @(posedge mclk);
	endtask
	initial
	begin
		#500000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		v = 16'($urandom(16412));
		ad = {3'h4, 4'($urandom)};
		{sh, sl} <= ad[3:0];
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("cfg rst", 16'h4127, cfg);
		chk("fast rst", 16'h0, 16'(fast));
		rd(d);
		chk("cfg rd", 16'h4127, d);
		v = 16'($urandom) & 16'h7FFF;
		wr(8'h00, v, 1'b1);
		chk("cfg out", v, cfg);
		rd(d);
		chk("cfg back", v, d);
		wr(8'h00, v | 16'h8000, 1'b1);
		chk("cfg self clr", 16'h4127, cfg);
		wr(8'h01, 16'($urandom), 1'b1);
		rd(d);
		chk("ro reg", 16'h0, d);
		send_meas();
		wr(8'h03, 16'h0, 1'b0);
		rd(d);
		chk("power nocal", exp_res(cal, meas.power), d);
		cal <= 1'b1;
		send_meas();
		rd(d);
		chk("power", exp_res(cal, meas.power), d);
		rd(d);
		chk("power again", exp_res(cal, meas.power), d);
		wr(8'h04, 16'h0, 1'b0);
		rd(d);
		chk("current", exp_res(cal, meas.current), d);
		wr(8'h01, 16'h0, 1'b0);
		rd(d);
		chk("shunt", meas.shunt, d);
		wr(8'h02, 16'h0, 1'b0);
		rd(d);
		chk("rail", meas.rail, d);
		m.start();
		m.wbyte({ad ^ 7'h01, 1'b0}, a);
		chk("foreign ack", 16'h0, 16'(a));
		m.stop();
		for (int i = 0; i < 3; i++)
		begin
			ad = {3'h4, 4'($urandom)};
			{sh, sl} <= ad[3:0];
			rd(d);
			chk("strap rd", meas.rail, d);
		end
		m.half = 250;
		m.start();
		m.wbyte(8'h08 | 8'($urandom & 7), a);
		chk("code ack", 16'h0, 16'(a));
		m.half = 10;
		chk("fast on", 16'h1, 16'(fast));
		m.start();
		m.wbyte({ad, 1'b1}, a);
		chk("fast kept", 16'h1, 16'(fast));
		m.rbyte(1'b1, b);
		m.rbyte(1'b0, b);
		m.stop();
		m.hold(10);
		chk("fast off", 16'h0, 16'(fast));
		alert <= 1'b1;
		m.hold(10);
		chk("alert low", 16'h0, 16'(alert_n));
		m.start();
		m.wbyte({7'h0C, 1'b1}, a);
		chk("ara ack", 16'h1, 16'(a));
		m.rbyte(1'b0, b);
		m.stop();
		chk("ara addr", 16'(ad), 16'(b[7:1]));
		alert <= 1'b0;
		m.hold(10);
		chk("alert clr", 16'h1, 16'(alert_n));
		wr(8'h00, 16'h0, 1'b0);
		m.start();
		m.wbyte({ad, 1'b1}, a);
		m.set(1'b0, 1'b1);
		chk("drive msb", 16'h1, 16'(sda_oe));
		chk("sda level", 16'h0, 16'(sda_o));
		m.hold(TO + 50);
		chk("timeout", 16'h0, 16'(sda_oe));
		m.stop();
		give_verdict();
	end
endmodule // pmi_port_tb
`default_nettype wire
